//--- verilog/fap_pkg.sv
// Purpose: shared types and constants of the flash access and write protection gate
// Assumes: one 40 MHz clock, synchronous active-high reset
// Notes:   wishbone offsets are byte addresses of 32-bit words
`default_nettype none
package fap_pkg;

   // ------------------------------------------------------------
   // fetch regions and access targets
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      FAP_FETCH_INTERNAL_FLASH = 2'b00,
      FAP_FETCH_INTERNAL_RAM   = 2'b01,
      FAP_FETCH_EXTENSION_RAM   = 2'b10,
      FAP_FETCH_EXT    = 2'b11
   } fap_region_t;

   // code 2'b11 is illegal and is refused
   typedef enum logic [1:0] {
      FAP_TGT_FDATA = 2'b00,
      FAP_TGT_FREG  = 2'b01,
      FAP_TGT_OTHER = 2'b10
   } fap_tgt_t;

   typedef struct packed {
      logic        valid;
      logic        write;
      logic        event_controller_transfer;
      fap_tgt_t    tgt;
      fap_region_t fetch;
   } fap_acc_t;

   // fuse image: 0 means programmed
   typedef struct packed {
      logic        access_protect_fuse;
      logic [15:0] nv_protect_disable_reg;
      logic [15:0] nv_protect_reenable_reg;
      logic [7:0]  nv_sector_write_protect_reg;
   } fap_fuse_t;

   // set-protection operation as seen by this block
   typedef struct packed {
      logic       valid;
      logic       wp_reg;
      logic [7:0] data;
   } fap_spr_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] mask;
   } fap_pe_t;

   // ------------------------------------------------------------
   // constants
   // ------------------------------------------------------------
   localparam logic [7:0]  FAP_ADR_TAU   = 8'h00;
   localparam logic [7:0]  FAP_ADR_STAT  = 8'h04;
   localparam logic [7:0]  FAP_ADR_MASK  = 8'h08;
   localparam logic [7:0]  FAP_ADR_STATE = 8'h0c;
   localparam int unsigned FAP_TEMP_UNPROTECT_BIT_POS  = 0;
   localparam int unsigned FAP_N_EV      = 4;
   localparam int unsigned FAP_EV_TRAP   = 0;
   localparam int unsigned FAP_EV_WREF   = 1;
   localparam int unsigned FAP_EV_WPF    = 2;
   localparam int unsigned FAP_EV_TAUIGN = 3;
   localparam logic [15:0] FAP_TRAP_NUM  = 16'h009b;
   localparam logic [3:0]  FAP_MASK_RST  = 4'h0;
   localparam fap_fuse_t   FAP_FUSE_RST  = '{1'b0, 16'hffff, 16'hffff, 8'h00};

   // number of programmed (zero) fuse bits
   function automatic logic [4:0] fap_zeros16(input logic [15:0] v);
      logic [4:0] n;
      n = 5'h00;
      for (int i = 0; i < 16; i++) begin
         n = n + {4'h0, ~v[i]};
      end
      return n;
   endfunction

endpackage
`default_nettype wire

//--- verilog/fap_fuse_latch.sv
// Purpose: copies the protection fuses into volatile state once after reset
// Assumes: fuse inputs are static and on the system clock
// Notes:   until the copy is taken every protection reads as active
`timescale 1ns/1ps
`default_nettype none
module fap_fuse_latch
   import fap_pkg::*;
(
   // clock and reset
   input  wire logic      clk_i,
   input  wire logic      rst_i,
   // fuse array
   input  wire fap_fuse_t fuse_i,
   // volatile copy
   output fap_fuse_t      fuse_o,
   output logic           loaded_o,
   output logic           load_pulse_o
);

   typedef enum logic {FL_WAIT = 1'b0, FL_DONE = 1'b1} fap_fl_t;

   fap_fl_t   st_q, st_d;
   fap_fuse_t fuse_q, fuse_d;
   logic      pulse_q, pulse_d;

   always_comb begin
      st_d    = st_q;
      fuse_d  = fuse_q;
      pulse_d = 1'b0;
      unique case (st_q)
         FL_WAIT: begin
            fuse_d  = fuse_i;
            pulse_d = 1'b1;
            st_d    = FL_DONE;
         end
         FL_DONE: begin
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_q    <= FL_WAIT;
         fuse_q  <= FAP_FUSE_RST;
         pulse_q <= 1'b0;
      end else begin
         st_q    <= st_d;
         fuse_q  <= fuse_d;
         pulse_q <= pulse_d;
      end
   end

   assign fuse_o       = fuse_q;
   assign loaded_o     = (st_q == FL_DONE);
   assign load_pulse_o = pulse_q;

endmodule
`default_nettype wire

//--- verilog/fap_sector_gate.sv
// Purpose: filters program/erase sector requests through the write protection
// Assumes: writable_i has a 1 for every sector that may be written
// Notes:   result is registered, one cycle after the request
`timescale 1ns/1ps
`default_nettype none
module fap_sector_gate #(
   parameter int unsigned SECT = 8
) (
   // clock and reset
   input  wire logic            clk_i,
   input  wire logic            rst_i,
   // request
   input  wire logic            req_i,
   input  wire logic [SECT-1:0] mask_i,
   input  wire logic [SECT-1:0] writable_i,
   // result
   output logic                 go_o,
   output logic [SECT-1:0]      go_mask_o,
   output logic                 wpf_o
);

   logic            go_q, go_d, wpf_q, wpf_d;
   logic [SECT-1:0] msk_q, msk_d;

   // protected sectors are skipped, the rest still proceed
   always_comb begin
      msk_d = req_i ? (mask_i & writable_i) : '0; // [R18]
      go_d  = |msk_d;
      wpf_d = req_i & |(mask_i & ~writable_i); // [R18]
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         go_q  <= 1'b0;
         msk_q <= '0;
         wpf_q <= 1'b0;
      end else begin
         go_q  <= go_d;
         msk_q <= msk_d;
         wpf_q <= wpf_d;
      end
   end

   assign go_o      = go_q;
   assign go_mask_o = msk_q;
   assign wpf_o     = wpf_q;

endmodule
`default_nettype wire

//--- verilog/fap_flash_guard.sv
// Purpose: access and write protection gate of the on-chip program flash
// Assumes: classic wishbone slave; acc_i, spr_i, pe_i are one-cycle requests
// Notes:   every decision is registered, answers come one cycle late
//
// Overview of operation
// R1: unprotect bit suspends access protection
// R2: unprotect bit writable only from flash code
// R3: protected flash data readable only from flash
// R4: foreign protected read gives dummy, trap 009Bh
// R5: foreign protected data write has no effect
// R6: event-controller flash transfers refused while protected
// R7: software enables protection via unprotect bit sequence
// R8: permanent disable/re-enable fuses, sixteen cycles max
// R9: software unprotects before programming permanent fuses
// R10: flash control register writes rejected while protected
// R11: access table by fetch region when protected
// R12: sector protected when its fuse bit is zero
// R13: set-protection writing one lifts sector protection
// R14: reset or writing zero restores sector protection
// R15: only volatile shadow changes, fuses stay zero
// R16: reset or clearing unprotect bit restores protection
// R17: protected during reset, fuses copied once
// R18: protected sector program sets error, others proceed
// R19: accesses classified by issuing fetch region
`timescale 1ns/1ps
`default_nettype none
module fap_flash_guard
   import fap_pkg::*;
(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire fap_region_t wb_fetch_i,
   output logic [31:0]      wb_dat_o,
   output logic             wb_ack_o,
   // cpu and event-controller accesses
   input  wire fap_acc_t    acc_i,
   output logic             acc_grant_o,
   output logic             acc_dummy_o,
   output logic             trap_o,
   output logic [15:0]      trap_num_o,
   // fuses and protection operations
   input  wire fap_fuse_t   fuse_i,
   input  wire fap_spr_t    spr_i,
   input  wire fap_pe_t     pe_i,
   output logic             sect_go_o,
   output logic [7:0]       sect_mask_o,
   output logic             wpf_o,
   // status
   output logic             prot_o,
   output logic             irq_o
);

   // ------------------------------------------------------------
   // fuse copy and protection state
   // ------------------------------------------------------------
   fap_fuse_t fuse;
   logic      loaded, ld_pulse, perm_off, prot_now;

   fap_fuse_latch u_fuse (
      .clk_i        (clk_i),
      .rst_i        (rst_i),
      .fuse_i       (fuse_i),
      .fuse_o       (fuse),
      .loaded_o     (loaded),
      .load_pulse_o (ld_pulse)
   );

   // a disable step counts only while not matched by a re-enable;
   // 16 fuse pairs bound the number of cycles
   assign perm_off = loaded & (fap_zeros16(fuse.nv_protect_disable_reg)
                    > fap_zeros16(fuse.nv_protect_reenable_reg)); // [R8]

   logic temp_unprotect_bit_q, temp_unprotect_bit_d;

   // forced active until the copy exists
   assign prot_now = ~loaded
                   | (~fuse.access_protect_fuse & ~temp_unprotect_bit_q & ~perm_off); // [R1] [R17]

   // ------------------------------------------------------------
   // wishbone decode
   // ------------------------------------------------------------
   logic        ack_q, ack_d;
   logic [31:0] dat_q, dat_d;
   logic        bus_req, bus_wr, bus_rd, tau_wr, from_fl_bus;

   assign bus_req     = wb_cyc_i & wb_stb_i & ~ack_q;
   assign bus_wr      = bus_req & wb_we_i;
   assign bus_rd      = bus_req & ~wb_we_i;
   assign tau_wr      = bus_wr & (wb_adr_i == FAP_ADR_TAU) & wb_sel_i[0];
   assign from_fl_bus = (wb_fetch_i == FAP_FETCH_INTERNAL_FLASH); // [R19]

   // unprotect bit: only code running from flash may change it
   always_comb begin
      temp_unprotect_bit_d = temp_unprotect_bit_q;
      if (tau_wr && from_fl_bus) begin
         temp_unprotect_bit_d = wb_dat_i[FAP_TEMP_UNPROTECT_BIT_POS]; // [R2] [R16]
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         temp_unprotect_bit_q <= 1'b0; // [R16]
      end else begin
         temp_unprotect_bit_q <= temp_unprotect_bit_d;
      end
   end

   // ------------------------------------------------------------
   // sector write protection shadow
   // ------------------------------------------------------------
   logic [7:0] wp_q, wp_d;

   // the fuse image is never rewritten here, so a lift is invisible
   // in the state register; software has to track it
   always_comb begin
      wp_d = wp_q;
      if (ld_pulse) begin
         wp_d = fuse.nv_sector_write_protect_reg; // [R12]
      end
      if (spr_i.valid && spr_i.wp_reg && loaded) begin
         wp_d = spr_i.data; // [R13] [R14] [R15]
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wp_q <= 8'h00; // [R14] [R17]
      end else begin
         wp_q <= wp_d;
      end
   end

   logic wpf_ev;

   fap_sector_gate #(
      .SECT (8)
   ) u_sect (
      .clk_i      (clk_i),
      .rst_i      (rst_i),
      .req_i      (pe_i.valid),
      .mask_i     (pe_i.mask),
      .writable_i (wp_q),
      .go_o       (sect_go_o),
      .go_mask_o  (sect_mask_o),
      .wpf_o      (wpf_ev)
   );

   assign wpf_o = wpf_ev;

   // ------------------------------------------------------------
   // access decision
   // ------------------------------------------------------------
   logic acc_ok, from_fl;
   logic grant_q, grant_d, dummy_q, dummy_d, trap_q, trap_d;
   logic prot_q, wref_ev;
   logic [15:0] tnum_q;

   assign from_fl = (acc_i.fetch == FAP_FETCH_INTERNAL_FLASH); // [R19]

   always_comb begin
      unique case (acc_i.tgt)
         FAP_TGT_FDATA: acc_ok = ~prot_now | (from_fl & ~acc_i.event_controller_transfer); // [R3] [R5] [R6] [R11]
         FAP_TGT_FREG:  acc_ok = ~prot_now
                               | (from_fl & ~acc_i.write & ~acc_i.event_controller_transfer); // [R10] [R11]
         FAP_TGT_OTHER: acc_ok = 1'b1; // [R11]
         default:       acc_ok = 1'b0;
      endcase
      grant_d = acc_i.valid & acc_ok;
      dummy_d = acc_i.valid & ~acc_ok & ~acc_i.write; // [R4]
      trap_d  = dummy_d & ~acc_i.event_controller_transfer; // [R4]
      wref_ev = acc_i.valid & ~acc_ok & acc_i.write; // [R5]
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         grant_q <= 1'b0;
         dummy_q <= 1'b0;
         trap_q  <= 1'b0;
         prot_q  <= 1'b1;
         tnum_q  <= 16'h0000;
      end else begin
         grant_q <= grant_d;
         dummy_q <= dummy_d;
         trap_q  <= trap_d;
         prot_q  <= prot_now;
         tnum_q  <= trap_d ? FAP_TRAP_NUM : 16'h0000;
      end
   end

   assign acc_grant_o = grant_q;
   assign acc_dummy_o = dummy_q;
   assign trap_o      = trap_q;
   assign trap_num_o  = tnum_q;
   assign prot_o      = prot_q;

   // ------------------------------------------------------------
   // events, interrupt and register read
   // ------------------------------------------------------------
   logic [3:0] stat_q, stat_d, mask_q, mask_d, ev;
   logic       irq_q, irq_d;

   always_comb begin
      ev = 4'h0;
      ev[FAP_EV_TRAP]   = trap_d;
      ev[FAP_EV_WREF]   = wref_ev;
      ev[FAP_EV_WPF]    = wpf_ev;
      ev[FAP_EV_TAUIGN] = tau_wr & ~from_fl_bus;
      // a new event wins over the clearing read
      stat_d = stat_q;
      if (bus_rd && wb_adr_i == FAP_ADR_STAT) begin
         stat_d = 4'h0;
      end
      stat_d = stat_d | ev;
      mask_d = mask_q;
      if (bus_wr && wb_adr_i == FAP_ADR_MASK && wb_sel_i[0]) begin
         mask_d = wb_dat_i[3:0];
      end
      irq_d = |(stat_d & mask_d);
      ack_d = bus_req;
      dat_d = 32'h0000_0000;
      if (bus_rd) begin
         unique case (wb_adr_i)
            FAP_ADR_TAU:   dat_d = {31'h0, temp_unprotect_bit_q};
            FAP_ADR_STAT:  dat_d = {28'h0, stat_q};
            FAP_ADR_MASK:  dat_d = {28'h0, mask_q};
            FAP_ADR_STATE: dat_d = {16'h0, fuse.nv_sector_write_protect_reg,
                                    5'h00, loaded, perm_off, prot_now}; // [R15]
            default:       dat_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         stat_q <= 4'h0;
         mask_q <= FAP_MASK_RST;
         irq_q  <= 1'b0;
         ack_q  <= 1'b0;
         dat_q  <= 32'h0000_0000;
      end else begin
         stat_q <= stat_d;
         mask_q <= mask_d;
         irq_q  <= irq_d;
         ack_q  <= ack_d;
         dat_q  <= dat_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;
   assign irq_o    = irq_q;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_temp_unprotect_bit_foreign_ignored: assert property ( // [R2]
      tau_wr && !from_fl_bus |=> temp_unprotect_bit_q == $past(temp_unprotect_bit_q))
      else $error("unprotect bit changed by non-flash code");

   a_temp_unprotect_bit_clear_reprotect: assert property ( // [R16]
      tau_wr && from_fl_bus && !wb_dat_i[0] && loaded
      && !fuse.access_protect_fuse && !perm_off |=> prot_now ##1 prot_o)
      else $error("clearing unprotect bit did not reprotect");

   a_unprot_read_ok: assert property ( // [R1]
      temp_unprotect_bit_q && loaded && acc_i.valid && !acc_i.write && !acc_i.event_controller_transfer
      && acc_i.tgt == FAP_TGT_FDATA |=> acc_grant_o)
      else $error("read refused while temporarily unprotected");

   a_trap_read: assert property ( // [R4]
      prot_now && acc_i.valid && !acc_i.write && !acc_i.event_controller_transfer && !from_fl
      && acc_i.tgt == FAP_TGT_FDATA
      |=> trap_o && acc_dummy_o && !acc_grant_o && trap_num_o == 16'h009b)
      else $error("protected foreign read not trapped");

   a_foreign_write_block: assert property ( // [R5]
      prot_now && acc_i.valid && acc_i.write && !from_fl
      && acc_i.tgt == FAP_TGT_FDATA |=> !acc_grant_o && !trap_o)
      else $error("protected foreign write granted");

   a_pec_refused: assert property ( // [R6]
      prot_now && acc_i.valid && acc_i.event_controller_transfer && acc_i.tgt != FAP_TGT_OTHER
      |=> !acc_grant_o)
      else $error("event-controller flash transfer granted");

   a_reg_write_block: assert property ( // [R10]
      prot_now && acc_i.valid && acc_i.write && acc_i.tgt == FAP_TGT_FREG
      |=> !acc_grant_o)
      else $error("flash register write granted while protected");

   a_other_always_ok: assert property ( // [R11]
      acc_i.valid && acc_i.tgt == FAP_TGT_OTHER |=> acc_grant_o)
      else $error("access outside flash refused");

   a_flash_fetch_read: assert property ( // [R3]
      acc_i.valid && !acc_i.write && !acc_i.event_controller_transfer && from_fl
      && acc_i.tgt == FAP_TGT_FDATA |=> acc_grant_o)
      else $error("flash code could not read flash data");

   a_load_once: assert property ( // [R17]
      $rose(loaded) |-> ld_pulse ##1 (loaded && !ld_pulse) [*3])
      else $error("fuse copy not taken exactly once");

   a_wp_shadow: assert property ( // [R13]
      spr_i.valid && spr_i.wp_reg && loaded && !ld_pulse
      |=> wp_q == $past(spr_i.data))
      else $error("set protection did not update shadow");

   a_wpf_flag: assert property ( // [R18]
      pe_i.valid && |(pe_i.mask & ~wp_q)
      |=> wpf_o && sect_mask_o == ($past(pe_i.mask) & $past(wp_q)) ##1 stat_q[2])
      else $error("write protect error not flagged");

endmodule
`default_nettype wire

//--- verification/fap_cpu_model.sv
// Purpose: cpu and event-controller side that issues flash accesses
// Assumes: one request per go pulse, launched on the next edge
// Notes:   idle fields toggle so a stale request never looks valid
`timescale 1ns/1ps
`default_nettype none
module fap_cpu_model
   import fap_pkg::*;
(
   // clock and reset
   input  wire logic     clk_i,
   input  wire logic     rst_i,
   // command from the bench
   input  wire logic     go_i,
   input  wire fap_acc_t cmd_i,
   // request to the guard
   output var fap_acc_t  acc_o
);
   // ----------------
   // request driver
   // ----------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         acc_o <= '0;
      end else if (go_i) begin
         acc_o <= cmd_i;
      end else begin
         acc_o <= fap_acc_t'({1'b0, ~acc_o[5:0]});
      end
   end
endmodule
`default_nettype wire

//--- verification/fap_flash_guard_bench.sv
// Purpose: self-checking bench of the flash access and write protection gate
// Assumes: 40 MHz clock, synchronous reset held three cycles
// Notes:   fuses change only under reset, as on silicon
`timescale 1ns/1ps
`default_nettype none
module fap_flash_guard_bench
   import fap_pkg::*;
   ;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'hf;
   logic [3:0]  bsel = 4'hf;
   logic [31:0] wdat = 32'h0;
   fap_region_t fetch = FAP_FETCH_INTERNAL_FLASH;
   logic [31:0] rdat;
   logic        ack;
   logic        go = 1'b0;
   fap_acc_t    cmd = '0;
   fap_acc_t    acc;
   logic        grant, dummy, trap, sgo, write_protect_error_flag, prot, irq;
   logic [15:0] tnum;
   logic [7:0]  smask;
   fap_fuse_t   fuse = '{1'b0, 16'hffff, 16'hffff, 8'h0f};
   fap_spr_t    spr = '0;
   fap_pe_t     pe = '0;
   logic [31:0] q;
   int          bad_count = 0;
   int          check_count = 0;
   int          cyc_n = 0;

   initial begin
      forever #12.5 clk_i = ~clk_i;
   end

   fap_cpu_model cpu_u (.clk_i(clk_i), .rst_i(rst_i), .go_i(go), .cmd_i(cmd), .acc_o(acc));

   fap_flash_guard dut_u (
      .clk_i(clk_i), .rst_i(rst_i),
      .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_fetch_i(fetch), .wb_dat_o(rdat), .wb_ack_o(ack),
      .acc_i(acc), .acc_grant_o(grant), .acc_dummy_o(dummy), .trap_o(trap), .trap_num_o(tnum),
      .fuse_i(fuse), .spr_i(spr), .pe_i(pe),
      .sect_go_o(sgo), .sect_mask_o(smask), .wpf_o(write_protect_error_flag), .prot_o(prot), .irq_o(irq)
   );

   // ----------------
   // shared tasks
   // ----------------
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // classic single cycle; request held until ack is sampled high
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input fap_region_t f);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      sel <= bsel;
      adr <= a;
      wdat <= d;
      fetch <= f;
      @(posedge clk_i);
      while (ack !== 1'b1) begin
         @(posedge clk_i);
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e, input string n);
      wb(1'b0, a, 32'h0, FAP_FETCH_INTERNAL_FLASH);
      chk(n, e, q);
   endtask

   task automatic settle_chk(input string n, input logic e, input logic got_now);
      @(posedge clk_i);
      #1;
      chk(n, {31'h0, e}, {31'h0, n == "irq" ? irq : prot});
   endtask

   function automatic fap_acc_t mk(input logic [1:0] wp, input fap_tgt_t t, input fap_region_t f);
      return '{1'b1, wp[1], wp[0], t, f};
   endfunction

   // e holds grant, dummy, trap
   task automatic req(input fap_acc_t c, input logic [2:0] e);
      @(posedge clk_i);
      cmd <= c;
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
      @(posedge clk_i);
      #1;
      chk("grant dummy trap", {29'h0, e}, {29'h0, grant, dummy, trap});
      chk("trap number", e[0] ? 32'h9b : 32'h0, {16'h0, tnum});
   endtask

   task automatic pe_req(input logic [7:0] m, input logic [7:0] e);
      @(posedge clk_i);
      pe <= '{1'b1, m};
      @(posedge clk_i);
      pe <= '0;
      #1;
      chk("sector go and mask", {23'h0, |e, e}, {23'h0, sgo, smask});
      chk("protect error", {31'h0, (m & ~e) != 8'h0}, {31'h0, write_protect_error_flag});
   endtask

   task automatic spr_op(input logic [7:0] d);
      @(posedge clk_i);
      spr <= '{1'b1, 1'b1, d};
      @(posedge clk_i);
      spr <= '0;
   endtask

   task automatic boot(input fap_fuse_t f, input logic ep);
      if ($time > 0) begin
         @(posedge clk_i);
      end
      fuse <= f;
      rst_i <= 1'b1;
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      chk("protected in reset", 32'h1, {31'h0, prot});
      repeat (4) @(posedge clk_i);
      #1;
      chk("protection after load", {31'h0, ep}, {31'h0, prot});
   endtask

   // ----------------
   // scenarios
   // ----------------
   task automatic t_regs;
      rd(FAP_ADR_STATE, 32'h0f05, "state");
      rd(FAP_ADR_MASK, 32'h0, "mask");
      rd(FAP_ADR_TAU, 32'h0, "unprotect bit");
      wb(1'b1, 8'h10, 32'hffff_ffff, FAP_FETCH_INTERNAL_FLASH);
      rd(8'h10, 32'h0, "unmapped read");
      rd(FAP_ADR_STAT, 32'h0, "status");
      $display("test registers done");
   endtask

   task automatic t_foreign;
      wb(1'b1, FAP_ADR_TAU, 32'h1, FAP_FETCH_INTERNAL_RAM);
      wb(1'b1, FAP_ADR_TAU, 32'h1, FAP_FETCH_EXT);
      rd(FAP_ADR_TAU, 32'h0, "unprotect bit");
      // a write without byte lane 0 must leave the unprotect bit alone
      bsel = 4'he;
      wb(1'b1, FAP_ADR_TAU, 32'h1, FAP_FETCH_INTERNAL_FLASH);
      bsel = 4'hf;
      rd(FAP_ADR_TAU, 32'h0, "unprotect bit lane");
      settle_chk("irq", 1'b0, irq);
      wb(1'b1, FAP_ADR_MASK, 32'h8, FAP_FETCH_INTERNAL_FLASH);
      settle_chk("irq", 1'b1, irq);
      rd(FAP_ADR_STAT, 32'h8, "status");
      settle_chk("irq", 1'b0, irq);
      rd(FAP_ADR_STAT, 32'h0, "status cleared");
      wb(1'b1, FAP_ADR_MASK, 32'h0, FAP_FETCH_INTERNAL_FLASH);
      settle_chk("prot", 1'b1, prot);
      $display("test foreign unprotect done");
   endtask

   task automatic t_sector;
      pe_req(8'hff, 8'h0f);
      rd(FAP_ADR_STAT, 32'h4, "status");
      pe_req(8'h0f, 8'h0f);
      spr_op(8'hff);
      pe_req(8'hff, 8'hff);
      rd(FAP_ADR_STATE, 32'h0f05, "sector fuse image");
      spr_op(8'h3f);
      pe_req(8'hc1, 8'h01);
      spr_op(8'hff);
      boot(fuse, 1'b1);
      pe_req(8'hff, 8'h0f);
      rd(FAP_ADR_STAT, 32'h4, "status after reset");
      $display("test sectors done");
   endtask

   task automatic t_table(input logic p);
      fap_region_t r;
      for (int i = 0; i < 4; i++) begin
         r = fap_region_t'(i[1:0]);
         req(mk(2'b00, FAP_TGT_FDATA, r), (p && i != 0) ? 3'b011 : 3'b100);
         req(mk(2'b00, FAP_TGT_FREG, r), (p && i != 0) ? 3'b011 : 3'b100);
         req(mk(2'b10, FAP_TGT_FDATA, r), (p && i != 0) ? 3'b000 : 3'b100);
         req(mk(2'b10, FAP_TGT_FREG, r), p ? 3'b000 : 3'b100);
         req(mk(2'b00, FAP_TGT_OTHER, r), 3'b100);
      end
      req(mk(2'b01, FAP_TGT_FDATA, FAP_FETCH_INTERNAL_RAM), p ? 3'b010 : 3'b100);
      req(mk(2'b11, FAP_TGT_FDATA, FAP_FETCH_EXTENSION_RAM), p ? 3'b000 : 3'b100);
      req(mk(2'b00, fap_tgt_t'(2'b11), FAP_FETCH_INTERNAL_FLASH), 3'b011);
      rd(FAP_ADR_STAT, p ? 32'h3 : 32'h1, "status");
      $display("test access table done");
   endtask

   task automatic t_unprotect;
      wb(1'b1, FAP_ADR_TAU, 32'h1, FAP_FETCH_INTERNAL_FLASH);
      settle_chk("prot", 1'b0, prot);
      rd(FAP_ADR_TAU, 32'h1, "unprotect bit");
      t_table(1'b0);
      wb(1'b1, FAP_ADR_TAU, 32'h0, FAP_FETCH_INTERNAL_FLASH);
      settle_chk("prot", 1'b1, prot);
      req(mk(2'b00, FAP_TGT_FDATA, FAP_FETCH_INTERNAL_RAM), 3'b011);
      wb(1'b1, FAP_ADR_TAU, 32'h1, FAP_FETCH_INTERNAL_FLASH);
      boot(fuse, 1'b1);
      $display("test unprotect done");
   endtask

   task automatic t_perm;
      boot('{1'b0, 16'hfffe, 16'hffff, 8'h0f}, 1'b0);
      rd(FAP_ADR_STATE, 32'h0f06, "state");
      boot('{1'b0, 16'hfffe, 16'hfffe, 8'h0f}, 1'b1);
      boot('{1'b0, 16'h0000, 16'h8000, 8'h0f}, 1'b0);
      boot('{1'b0, 16'h0000, 16'h0000, 8'h0f}, 1'b1);
      boot('{1'b1, 16'hffff, 16'hffff, 8'h0f}, 1'b0);
      req(mk(2'b00, FAP_TGT_FDATA, FAP_FETCH_EXT), 3'b100);
      $display("test permanent fuses done");
   endtask

   // ----------------
   // run and timeout
   // ----------------
   always @(posedge clk_i) begin
      cyc_n <= cyc_n + 1;
      if (cyc_n == 20000) begin
         bad_count++;
         print_verdict;
      end
   end

   initial begin
      boot(fuse, 1'b1);
      t_regs;
      t_foreign;
      t_sector;
      t_table(1'b1);
      t_unprotect;
      t_perm;
      print_verdict;
   end
endmodule
`default_nettype wire
